// File: hdl/ibd_pkg.sv
// Package of constants for the ISA bridge decode and control block
//==========================================================
// What this block does
// - Forward ISA memory in enabled 16 KB ROM blocks C0000h-DFFFFh to PCI.
// - Hole start field gives ISA address bits 23 to 16 of hole base.
// - Hole enable set stops forwarding inside hole; clear forwards; resets zero.
// - Hole size field is thermometer mask, 64 KB up to 8 MB.
// - Non-x86 mode: reset-drive bit asserts PCI and ISA reset 1 ms, self-clears.
// - ISA clock is PCI clock divided by three-bit select field.
// - Extended BIOS enable selects ROM for FFF80000h to FFFDFFFFh.
// - Lower BIOS enable selects ROM for three 64 KB E-segment windows.
// - BIOS write protect withholds ROM select on writes.
// - Upper BIOS enable resets one, selects ROM for three F-segment windows.
// - x86 keyboard select enable gives code 11 on ports 60h,62h,64h,66h.
// - x86 clock chip select enable gives code 01 on ports 70h-77h.
// - Coprocessor error enable makes shared pin the coprocessor error input.
// - Fast gate port enable claims port 92 internally, else passes to ISA.
// - Keyboard reset emulation: init pulse over 4 clocks, or hard reset 1 ms.
// - Gate A20 emulation in x86 mode follows keyboard controller command.
// - I/O recovery bit inserts 4 or 8 ISA clocks after 16 or 8-bit I/O.
// - x86 mode: enabled IRQ 0-7 break events deassert power-management-active.
package ibd_pkg;
   //==========================================================
   // Register byte addresses
   localparam logic [5:0] ADDR_ROM_FWD = 6'h00;
   localparam logic [5:0] ADDR_HOLE_START = 6'h04;
   localparam logic [5:0] ADDR_HOLE_SIZE = 6'h08;
   localparam logic [5:0] ADDR_CLK_DIV = 6'h0c;
   localparam logic [5:0] ADDR_CS_CTRL = 6'h10;
   localparam logic [5:0] ADDR_SYS_CTRL = 6'h14;
   localparam logic [5:0] ADDR_BUS_CTRL = 6'h18;
   localparam logic [5:0] ADDR_IRQ_WAKE = 6'h1c;
   localparam logic [5:0] ADDR_INT_STAT = 6'h20;
   localparam logic [5:0] ADDR_INT_MASK = 6'h24;
   //==========================================================
   // Reset values
   localparam logic [7:0] RST_CS_CTRL = 8'h33;
   localparam logic [7:0] RST_SYS_CTRL = 8'h04;
   //==========================================================
   // Field positions
   localparam int HOLE_EN_BIT = 7;
   localparam int RST_DRV_BIT = 3;
   localparam int CS_EBIOS_BIT = 7;
   localparam int CS_LBIOS_BIT = 6;
   localparam int CS_WP_BIT = 5;
   localparam int CS_UBIOS_BIT = 4;
   localparam int CS_KBC_BIT = 1;
   localparam int CS_RTC_BIT = 0;
   localparam int SYS_COPROCESSOR_ERROR_N_BIT = 4;
   localparam int SYS_P92_BIT = 2;
   localparam int SYS_KBRC_BIT = 1;
   localparam int SYS_A20_BIT = 0;
   localparam int BUS_IOREC_BIT = 2;
   // Interrupt status bits
   localparam int IS_RESET_DONE = 0;
   localparam int IS_BREAK = 1;
   localparam int IS_KB_RESET = 2;
   //==========================================================
   // Encoded chip select values
   localparam logic [1:0] XCS_NONE = 2'h0;
   localparam logic [1:0] XCS_RTC = 2'h1;
   localparam logic [1:0] XCS_ROM = 2'h3;
   // Keyboard controller commands
   localparam logic [7:0] KBC_CMD_RESET = 8'hfe;
   localparam logic [7:0] KBC_CMD_A20 = 8'hd1;
   //==========================================================
   // Timing
   localparam int CLK_HZ = 50000000;
   localparam int RESET_US = 1000;
   localparam int RESET_CYC = (CLK_HZ / 1000000) * RESET_US;
   localparam int INIT_MIN_CLK = 4;
   localparam int INIT_CYC = INIT_MIN_CLK + 2;
   localparam int REC16_BCLK = 4;
   localparam int REC8_BCLK = 8;
endpackage

// File: hdl/ibd_top.sv
// Top of the ISA bridge decode and control block
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module ibd_top import ibd_pkg::*; #(
   parameter int RESET_CYCLES = RESET_CYC
) (
   input wire logic I_CLOCK, // 50 MHz PCI clock
   input wire logic I_RST_N, // Async reset, low
   input wire logic i_ce, // Clock enable
   input wire logic i_awvalid, // AXI write address valid
   output logic o_awready, // AXI write address ready
   input wire logic [5:0] i_awaddr, // AXI write address
   input wire logic i_wvalid, // AXI write data valid
   output logic o_wready, // AXI write data ready
   input wire logic [31:0] i_wdata, // AXI write data
   input wire logic [3:0] i_wstrb, // AXI byte strobes
   output logic o_bvalid, // AXI write response valid
   input wire logic i_bready, // AXI write response ready
   output logic [1:0] o_bresp, // AXI write response
   input wire logic i_arvalid, // AXI read address valid
   output logic o_arready, // AXI read address ready
   input wire logic [5:0] i_araddr, // AXI read address
   output logic o_rvalid, // AXI read data valid
   input wire logic i_rready, // AXI read data ready
   output logic [31:0] o_rdata, // AXI read data
   output logic [1:0] o_rresp, // AXI read response
   input wire logic i_x86_mode, // Host mode strap, 1 = x86
   input wire logic i_cyc_valid, // Decode cycle present
   input wire logic i_cyc_mem, // 1 = memory, 0 = I/O
   input wire logic i_cyc_write, // 1 = write
   input wire logic i_cyc_isa, // 1 = ISA master memory cycle
   input wire logic i_cyc_16bit, // 1 = 16-bit I/O
   input wire logic [31:0] i_cyc_addr, // Cycle address
   input wire logic i_io_done, // ISA I/O cycle ended, pulse
   input wire logic [7:0] i_kbc_cmd, // Keyboard command byte
   input wire logic i_kbc_cmd_valid, // Command written to port 64h
   input wire logic i_kbc_data_valid, // Data written to port 60h
   input wire logic [7:0] i_kbc_data, // Data byte
   input wire logic [7:0] i_irq, // IRQ lines 7..0
   input wire logic i_shared_pin, // Coprocessor error / other input
   output logic O_FWD_PCI, // Forward ISA memory to PCI
   output logic [1:0] O_ENCODED_CHIP_SELECT, // Encoded select
   output logic O_ROM_SELECT, // ROM select, non-x86 mode
   output logic O_PORT92_CLAIM, // Port 92 claimed internally
   output logic O_PCI_RESET_N, // PCI reset, low
   output logic O_EXPANSION_BUS_RESET, // ISA reset, high
   output logic O_HOST_HARD_RESET_N, // Hard reset, low
   output logic O_INIT, // Processor init
   output logic O_GATE_A20, // Gate A20
   output logic O_COPROCESSOR_ERROR_N, // Error input seen, low
   output logic O_BCLK, // ISA bus clock
   output logic O_IO_RECOVERY, // Recovery delay running
   output logic O_POWER_MGMT_ACTIVE_N, // Power management active, low
   output logic O_IRQ // Interrupt
);
   //==========================================================
   // Register and bus state
   logic [7:0] rom_fwd_q, rom_fwd_d, hole_start_q, hole_start_d, hole_size_q, hole_size_d;
   logic [7:0] clk_div_q, clk_div_d, cs_ctrl_q, cs_ctrl_d, sys_ctrl_q, sys_ctrl_d;
   logic [7:0] bus_ctrl_q, bus_ctrl_d, irq_wake_q, irq_wake_d;
   logic [2:0] int_stat_q, int_stat_d, int_mask_q, int_mask_d;
   logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [5:0] awaddr_q, awaddr_d;
   logic [7:0] wdata_q, wdata_d;
   logic wstrb_q, wstrb_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rst_cnt_q, rst_cnt_d;
   logic [2:0] init_cnt_q, init_cnt_d;
   logic [31:0] hrst_cnt_q, hrst_cnt_d;
   logic a20_q, a20_d, a20_wait_q, a20_wait_d;
   logic [3:0] div_cnt_q, div_cnt_d;
   logic bclk_q, bclk_d;
   logic [3:0] rec_cnt_q, rec_cnt_d;
   logic pm_act_n_q, pm_act_n_d;
   logic [7:0] irq_prev_q;
   logic fwd_q, fwd_d, rom_q, rom_d, p92_q, p92_d, coprocessor_error_n_q, coprocessor_error_n_d;
   logic [1:0] xcs_q, xcs_d;
   logic irq_q, irq_d;
   logic wr_fire, rd_fire, rst_done, brk_evt, kb_rst_evt;

   // Valid register byte address check, shared by reads and writes
   function automatic logic addr_ok(input logic [5:0] a);
      addr_ok = (a[1:0] == 2'h0) && (a <= ADDR_INT_MASK);
   endfunction

   // Divisor for each select code; reserved codes fall back to 4
   function automatic logic [3:0] div_of(input logic [2:0] s);
      unique case (s)
         3'h0: div_of = 4'h4;
         3'h1: div_of = 4'h3;
         3'h2: div_of = 4'h2;
         3'h4: div_of = 4'h6;
         default: div_of = 4'h4;
      endcase
   endfunction

   // 64 KB window match on address bits 31..16
   function automatic logic win(input logic [31:0] a, input logic [15:0] base);
      win = (a[31:16] == base);
   endfunction

   //==========================================================
   // AXI4-Lite slave: address and data taken in either order
   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (i_awvalid && !aw_q && !bvalid_q) begin
         aw_d = 1'b1;
         awaddr_d = i_awaddr;
      end
      if (i_wvalid && !w_q && !bvalid_q) begin
         w_d = 1'b1;
         wdata_d = i_wdata[7:0];
         wstrb_d = i_wstrb[0];
      end
      if (wr_fire) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = addr_ok(awaddr_q) ? 2'h0 : 2'h2;
      end else if (bvalid_q && i_bready) begin
         bvalid_d = 1'b0;
      end
      if (rd_fire) begin
         rvalid_d = 1'b1;
         rresp_d = addr_ok(i_araddr) ? 2'h0 : 2'h2;
         unique case (i_araddr)
            ADDR_ROM_FWD: rdata_d = {24'h0, rom_fwd_q};
            ADDR_HOLE_START: rdata_d = {24'h0, hole_start_q};
            ADDR_HOLE_SIZE: rdata_d = {24'h0, hole_size_q};
            ADDR_CLK_DIV: rdata_d = {24'h0, clk_div_q};
            ADDR_CS_CTRL: rdata_d = {24'h0, cs_ctrl_q};
            ADDR_SYS_CTRL: rdata_d = {24'h0, sys_ctrl_q};
            ADDR_BUS_CTRL: rdata_d = {24'h0, bus_ctrl_q};
            ADDR_IRQ_WAKE: rdata_d = {24'h0, irq_wake_q};
            ADDR_INT_STAT: rdata_d = {29'h0, int_stat_q};
            ADDR_INT_MASK: rdata_d = {29'h0, int_mask_q};
            default: rdata_d = 32'h0;
         endcase
      end else if (rvalid_q && i_rready) begin
         rvalid_d = 1'b0;
      end
   end
   assign wr_fire = aw_q && w_q && !bvalid_q;
   assign rd_fire = i_arvalid && !rvalid_q;

   //==========================================================
   // Register file; hardware self-clear of reset drive wins over a write
   always_comb begin
      logic wr;
      wr = wr_fire && wstrb_q;
      rom_fwd_d = rom_fwd_q;
      hole_start_d = hole_start_q;
      hole_size_d = hole_size_q;
      clk_div_d = clk_div_q;
      cs_ctrl_d = cs_ctrl_q;
      sys_ctrl_d = sys_ctrl_q;
      bus_ctrl_d = bus_ctrl_q;
      irq_wake_d = irq_wake_q;
      int_mask_d = int_mask_q;
      if (wr) begin
         unique case (awaddr_q)
            ADDR_ROM_FWD: rom_fwd_d = wdata_q;
            ADDR_HOLE_START: hole_start_d = wdata_q;
            ADDR_HOLE_SIZE: hole_size_d = wdata_q;
            ADDR_CLK_DIV: clk_div_d = {4'h0, wdata_q[3:0]};
            ADDR_CS_CTRL: cs_ctrl_d = {wdata_q[7:4], 2'h0, wdata_q[1:0]};
            ADDR_SYS_CTRL: sys_ctrl_d = {1'b0, wdata_q[6], 1'b0, wdata_q[4], 1'b0, wdata_q[2:0]};
            ADDR_BUS_CTRL: bus_ctrl_d = {5'h0, wdata_q[2:1], 1'b0};
            ADDR_IRQ_WAKE: irq_wake_d = wdata_q;
            ADDR_INT_MASK: int_mask_d = wdata_q[2:0];
            default: ;
         endcase
      end
      // Reset drive only arms in the non-x86 mode
      if (i_x86_mode) begin
         clk_div_d[RST_DRV_BIT] = 1'b0;
      end
      if (rst_done) begin
         clk_div_d[RST_DRV_BIT] = 1'b0;
      end
   end

   //==========================================================
   // Timed resets, init pulse and Gate A20 tracking
   always_comb begin
      rst_cnt_d = rst_cnt_q;
      init_cnt_d = init_cnt_q;
      hrst_cnt_d = hrst_cnt_q;
      a20_d = a20_q;
      a20_wait_d = a20_wait_q;
      kb_rst_evt = 1'b0;
      rst_done = 1'b0;
      if (clk_div_q[RST_DRV_BIT] && !i_x86_mode) begin
         rst_cnt_d = rst_cnt_q + 32'h1;
         if (rst_cnt_q == 32'(RESET_CYCLES - 1)) begin
            rst_done = 1'b1;
            rst_cnt_d = 32'h0;
         end
      end
      if (init_cnt_q != 3'h0) begin
         init_cnt_d = init_cnt_q - 3'h1;
      end
      if (hrst_cnt_q != 32'h0) begin
         hrst_cnt_d = hrst_cnt_q - 32'h1;
      end
      if (i_kbc_cmd_valid && i_kbc_cmd == KBC_CMD_RESET && sys_ctrl_q[SYS_KBRC_BIT]) begin
         kb_rst_evt = 1'b1;
         if (i_x86_mode) begin
            init_cnt_d = 3'(INIT_CYC);
         end else begin
            hrst_cnt_d = 32'(RESET_CYCLES);
         end
      end
      // Command D1h then a data byte whose bit 1 sets A20
      if (i_kbc_cmd_valid) begin
         a20_wait_d = (i_kbc_cmd == KBC_CMD_A20);
      end else if (i_kbc_data_valid && a20_wait_q) begin
         a20_wait_d = 1'b0;
         if (sys_ctrl_q[SYS_A20_BIT] && i_x86_mode) begin
            a20_d = i_kbc_data[1];
         end
      end
   end

   //==========================================================
   // ISA clock divider and I/O recovery counter in ISA clocks
   always_comb begin
      logic [3:0] dv;
      logic fall;
      dv = div_of(clk_div_q[2:0]);
      div_cnt_d = div_cnt_q + 4'h1;
      bclk_d = bclk_q;
      fall = 1'b0;
      if (div_cnt_q >= dv - 4'h1) begin
         div_cnt_d = 4'h0;
      end
      if (div_cnt_q == 4'h0) begin
         bclk_d = 1'b1;
      end else if (div_cnt_q == (dv >> 1)) begin
         bclk_d = 1'b0;
         fall = 1'b1;
      end
      rec_cnt_d = rec_cnt_q;
      if (i_io_done && bus_ctrl_q[BUS_IOREC_BIT]) begin
         rec_cnt_d = i_cyc_16bit ? 4'(REC16_BCLK) : 4'(REC8_BCLK);
      end else if (fall && rec_cnt_q != 4'h0) begin
         rec_cnt_d = rec_cnt_q - 4'h1;
      end
   end

   //==========================================================
   // Address decode; outputs registered one clock after the cycle
   always_comb begin
      logic [7:0] msk, hit;
      logic rom_hit, in_hole, rom_blk;
      logic [3:0] blk;
      msk = ~{1'b0, hole_size_q[6:0]};
      hit = (i_cyc_addr[23:16] ^ hole_start_q) & msk;
      in_hole = hole_size_q[HOLE_EN_BIT] && (hit == 8'h0);
      blk = i_cyc_addr[17:14] - 4'h0;
      rom_blk = (i_cyc_addr[23:17] == 7'h06) && rom_fwd_q[3'(blk)];
      fwd_d = i_cyc_valid && i_cyc_mem && i_cyc_isa && rom_blk && !in_hole;
      rom_hit = 1'b0;
      if (cs_ctrl_q[CS_EBIOS_BIT] && i_cyc_addr >= 32'hfff80000
            && i_cyc_addr <= 32'hfffdffff) begin
         rom_hit = 1'b1;
      end
      if (cs_ctrl_q[CS_LBIOS_BIT] && (win(i_cyc_addr, 16'hfffe) || win(i_cyc_addr, 16'hffee)
            || win(i_cyc_addr, 16'h000e))) begin
         rom_hit = 1'b1;
      end
      if (cs_ctrl_q[CS_UBIOS_BIT] && (win(i_cyc_addr, 16'hffff) || win(i_cyc_addr, 16'hffef)
            || win(i_cyc_addr, 16'h000f))) begin
         rom_hit = 1'b1;
      end
      rom_hit = rom_hit && i_cyc_valid && i_cyc_mem
         && !(i_cyc_write && cs_ctrl_q[CS_WP_BIT]);
      xcs_d = XCS_NONE;
      rom_d = 1'b0;
      if (rom_hit) begin
         if (i_x86_mode) begin
            xcs_d = XCS_ROM;
         end else begin
            rom_d = 1'b1;
         end
      end else if (i_cyc_valid && !i_cyc_mem && i_x86_mode) begin
         if (cs_ctrl_q[CS_KBC_BIT] && i_cyc_addr[15:3] == 13'h000c && !i_cyc_addr[0]) begin
            xcs_d = XCS_ROM;
         end else if (cs_ctrl_q[CS_RTC_BIT] && i_cyc_addr[15:3] == 13'h000e) begin
            xcs_d = XCS_RTC;
         end
      end
      p92_d = i_cyc_valid && !i_cyc_mem && i_cyc_addr[15:0] == 16'h0092
         && sys_ctrl_q[SYS_P92_BIT];
      coprocessor_error_n_d = !(sys_ctrl_q[SYS_COPROCESSOR_ERROR_N_BIT] && !i_shared_pin);
      // Break events: rising enabled IRQ ends power management
      brk_evt = i_x86_mode && |(i_irq & ~irq_prev_q & irq_wake_q);
      pm_act_n_d = brk_evt ? 1'b1 : pm_act_n_q;
      // Set wins over the clear-on-read of the status register
      int_stat_d = int_stat_q;
      if (rd_fire && i_araddr == ADDR_INT_STAT) begin
         int_stat_d = 3'h0;
      end
      int_stat_d = int_stat_d | {kb_rst_evt, brk_evt, rst_done};
      irq_d = |(int_stat_d & int_mask_q);
   end

   //==========================================================
   // All state registers
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         {aw_q, w_q, bvalid_q, rvalid_q, wstrb_q} <= 5'h0;
         awaddr_q <= 6'h0;
         wdata_q <= 8'h0;
         rdata_q <= 32'h0;
         bresp_q <= 2'h0;
         rresp_q <= 2'h0;
         rom_fwd_q <= 8'h00;
         hole_start_q <= 8'h00;
         hole_size_q <= 8'h00;
         clk_div_q <= 8'h00;
         cs_ctrl_q <= RST_CS_CTRL;
         sys_ctrl_q <= RST_SYS_CTRL;
         bus_ctrl_q <= 8'h00;
         irq_wake_q <= 8'h00;
         int_stat_q <= 3'h0;
         int_mask_q <= 3'h0;
         rst_cnt_q <= 32'h0;
         init_cnt_q <= 3'h0;
         hrst_cnt_q <= 32'h0;
         a20_q <= 1'b0;
         a20_wait_q <= 1'b0;
         div_cnt_q <= 4'h0;
         bclk_q <= 1'b0;
         rec_cnt_q <= 4'h0;
         pm_act_n_q <= 1'b0;
         irq_prev_q <= 8'h00;
         {fwd_q, rom_q, p92_q, irq_q} <= 4'h0;
         coprocessor_error_n_q <= 1'b1;
         xcs_q <= XCS_NONE;
      end else if (i_ce) begin
         {aw_q, w_q, bvalid_q, rvalid_q, wstrb_q} <= {aw_d, w_d, bvalid_d, rvalid_d, wstrb_d};
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         bresp_q <= bresp_d;
         rresp_q <= rresp_d;
         rom_fwd_q <= rom_fwd_d;
         hole_start_q <= hole_start_d;
         hole_size_q <= hole_size_d;
         clk_div_q <= clk_div_d;
         cs_ctrl_q <= cs_ctrl_d;
         sys_ctrl_q <= sys_ctrl_d;
         bus_ctrl_q <= bus_ctrl_d;
         irq_wake_q <= irq_wake_d;
         int_stat_q <= int_stat_d;
         int_mask_q <= int_mask_d;
         rst_cnt_q <= rst_cnt_d;
         init_cnt_q <= init_cnt_d;
         hrst_cnt_q <= hrst_cnt_d;
         a20_q <= a20_d;
         a20_wait_q <= a20_wait_d;
         div_cnt_q <= div_cnt_d;
         bclk_q <= bclk_d;
         rec_cnt_q <= rec_cnt_d;
         pm_act_n_q <= pm_act_n_d;
         irq_prev_q <= i_irq;
         {fwd_q, rom_q, p92_q, irq_q} <= {fwd_d, rom_d, p92_d, irq_d};
         coprocessor_error_n_q <= coprocessor_error_n_d;
         xcs_q <= xcs_d;
      end
   end

   //==========================================================
   // Port assignments, all from flip-flops
   assign o_awready = !aw_q && !bvalid_q;
   assign o_wready = !w_q && !bvalid_q;
   assign o_arready = !rvalid_q;
   assign o_bvalid = bvalid_q;
   assign o_bresp = bresp_q;
   assign o_rvalid = rvalid_q;
   assign o_rdata = rdata_q;
   assign o_rresp = rresp_q;
   assign O_FWD_PCI = fwd_q;
   assign O_ENCODED_CHIP_SELECT = xcs_q;
   assign O_ROM_SELECT = rom_q;
   assign O_PORT92_CLAIM = p92_q;
   assign O_PCI_RESET_N = !clk_div_q[RST_DRV_BIT];
   assign O_EXPANSION_BUS_RESET = clk_div_q[RST_DRV_BIT];
   assign O_HOST_HARD_RESET_N = (hrst_cnt_q == 32'h0);
   assign O_INIT = (init_cnt_q != 3'h0);
   assign O_GATE_A20 = a20_q;
   assign O_COPROCESSOR_ERROR_N = coprocessor_error_n_q;
   assign O_BCLK = bclk_q;
   assign O_IO_RECOVERY = (rec_cnt_q != 4'h0);
   assign O_POWER_MGMT_ACTIVE_N = pm_act_n_q;
   assign O_IRQ = irq_q;

   //==========================================================
   // Checks
   property p_rst_clear;
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      (i_ce && rst_done) |=> !clk_div_q[RST_DRV_BIT];
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("reset drive not cleared");
   property p_init_len;
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      $rose(O_INIT) |-> O_INIT [*5];
   endproperty
   a_init_len: assert property (p_init_len) else $error("init pulse too short");
   property p_wp;
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      (i_ce && i_cyc_valid && i_cyc_mem && i_cyc_write && cs_ctrl_q[CS_WP_BIT])
         |=> xcs_q != XCS_ROM && !rom_q;
   endproperty
   a_wp: assert property (p_wp) else $error("rom select on protected write");
   property p_xcs_mode;
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      !i_x86_mode && $stable(i_x86_mode) |=> xcs_q == XCS_NONE;
   endproperty
   a_xcs_mode: assert property (p_xcs_mode) else $error("select outside x86 mode");
   property p_hole;
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      (i_ce && hole_size_q[HOLE_EN_BIT] && i_cyc_addr[23:16] == hole_start_q) |=> !O_FWD_PCI;
   endproperty
   a_hole: assert property (p_hole) else $error("forwarded inside hole");
   property p_rec;
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      (i_ce && i_io_done && !bus_ctrl_q[BUS_IOREC_BIT] && !O_IO_RECOVERY) |=> !O_IO_RECOVERY;
   endproperty
   a_rec: assert property (p_rec) else $error("recovery without enable");
   property p_brk;
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      (i_ce && brk_evt) |=> O_POWER_MGMT_ACTIVE_N && int_stat_q[IS_BREAK];
   endproperty
   a_brk: assert property (p_brk) else $error("break event missed");
   property p_rtc;
      @(posedge I_CLOCK) disable iff (!I_RST_N)
      (i_ce && xcs_d == XCS_RTC) |-> i_cyc_addr[15:3] == 13'h000e && cs_ctrl_q[CS_RTC_BIT];
   endproperty
   a_rtc: assert property (p_rtc) else $error("bad clock chip select");
endmodule

// File: verif/ibd_peer.sv
// Keyboard controller and IRQ source model
`timescale 1ns/10ps
module ibd_peer (
   input wire logic i_clk, // Clock
   input wire logic i_go, // Send one byte
   input wire logic [7:0] i_byte, // Byte to send
   input wire logic [7:0] i_lines, // Wanted IRQ levels
   output logic [7:0] o_cmd = 8'h00, // Command byte
   output logic o_cmd_valid = 1'b0, // Command strobe
   output logic [7:0] o_irq = 8'h00 // IRQ lines
);
   //====================
   // Idle byte flips each cycle so a stale value never passes for a command
   always @(posedge i_clk) begin
      o_cmd_valid <= i_go;
      o_cmd <= i_go ? i_byte : ~o_cmd;
      o_irq <= i_lines;
   end
endmodule

// File: verif/isa_bridge_decode_control_test.sv
// Self-checking bench for the ISA bridge decode and control block
`timescale 1ns/10ps
module isa_bridge_decode_control_test import ibd_pkg::*;;
   //====================
   // Bench state
   logic clk = 0, rst_n = 0, aw = 0, w = 0, br = 0, ar = 0, rr = 0, x86 = 1, cv = 0, cm = 0;
   logic cw = 0, ci = 0, go = 0, awr, wrd, bv, arr, rv, fwd, xrst, init, pm_n, irq, kval;
   logic sp = 1, iod = 0, coprocessor_error_n_n, rec, p92, hrst_n;
   logic [5:0] awa = 0, ara = 0;
   logic [7:0] wd = 0, byt = 0, lines = 0, kcmd, kirq;
   logic [31:0] ca = 0, rdata, sd;
   logic [1:0] bresp, sb, xcs, resp;
   logic [4:0] sm;
   int error_cnt = 0, comparisons = 0, cyc = 0, nrst = 0, ninit = 0, nhrst = 0;
   // Rows: hole size, mem, write, isa, address, forward, encoded select
   logic [45:0] tbl [14] = '{{8'h00, 3'h5, 32'hc0000, 3'h4}, {8'h00, 3'h5, 32'hc4000, 3'h0},
      {8'h00, 3'h5, 32'hdc000, 3'h4}, {8'h81, 3'h5, 32'hdc000, 3'h0},
      {8'h80, 3'h5, 32'hdc000, 3'h4}, {8'h01, 3'h5, 32'hdc000, 3'h4},
      {8'h80, 3'h5, 32'hc0000, 3'h0},
      {8'h00, 3'h4, 32'hfff80000, 3'h3}, {8'h00, 3'h4, 32'he0000, 3'h3},
      {8'h00, 3'h6, 32'he0000, 3'h0}, {8'h00, 3'h4, 32'hf0000, 3'h0},
      {8'h00, 3'h0, 32'h64, 3'h3}, {8'h00, 3'h0, 32'h77, 3'h1}, {8'h00, 3'h0, 32'h78, 3'h0}};
   ibd_top #(.RESET_CYCLES(20)) DUT (.I_CLOCK(clk), .I_RST_N(rst_n), .i_ce(1'b1),
      .i_awvalid(aw), .o_awready(awr), .i_awaddr(awa), .i_wvalid(w), .o_wready(wrd),
      .i_wdata({24'h0, wd}), .i_wstrb({4{w}}), .o_bvalid(bv), .i_bready(br), .o_bresp(bresp),
      .i_arvalid(ar), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(rr),
      .o_rdata(rdata), .o_rresp(), .i_x86_mode(x86), .i_cyc_valid(cv), .i_cyc_mem(cm),
      .i_cyc_write(cw), .i_cyc_isa(ci), .i_cyc_16bit(1'b0), .i_cyc_addr(ca), .i_io_done(iod),
      .i_kbc_cmd(kcmd), .i_kbc_cmd_valid(kval), .i_kbc_data_valid(1'b0), .i_kbc_data(kcmd),
      .i_irq(kirq), .i_shared_pin(sp), .O_FWD_PCI(fwd), .O_ENCODED_CHIP_SELECT(xcs),
      .O_ROM_SELECT(), .O_PORT92_CLAIM(p92), .O_PCI_RESET_N(), .O_EXPANSION_BUS_RESET(xrst),
      .O_HOST_HARD_RESET_N(hrst_n), .O_INIT(init), .O_GATE_A20(),
      .O_COPROCESSOR_ERROR_N(coprocessor_error_n_n), .O_BCLK(), .O_IO_RECOVERY(rec),
      .O_POWER_MGMT_ACTIVE_N(pm_n), .O_IRQ(irq));
   ibd_peer PEER (.i_clk(clk), .i_go(go), .i_byte(byt), .i_lines(lines), .o_cmd(kcmd),
      .o_cmd_valid(kval), .o_irq(kirq));
   //====================
   // Clock, and mid-cycle samples so bus decisions never race the edge
   initial forever #10 clk = ~clk;
   always @(negedge clk) begin
      sm <= {awr, wrd, bv, arr, rv};
      sd <= rdata;
      sb <= bresp;
      nrst += (xrst === 1'b1);
      ninit += (init === 1'b1);
      nhrst += (hrst_n === 1'b0);
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         finish_test();
      end
   end
   // Count and report a comparison
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Bus write: address and data offered together, each dropped once taken
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      awa <= a; wd <= d; aw <= 1; w <= 1; br <= 1;
      do begin
         @(posedge clk);
         if (sm[4]) aw <= 0;
         if (sm[3]) w <= 0;
      end while (!sm[2]);
      resp = sb;
      br <= 0;
      @(posedge clk);
   endtask
   task automatic rc(input logic [5:0] a, input logic [7:0] e);
      ara <= a; ar <= 1; rr <= 1;
      do begin
         @(posedge clk);
         if (sm[1]) ar <= 0;
      end while (!sm[0]);
      rr <= 0;
      chk(sd, e);
      @(posedge clk);
   endtask
   //====================
   // Reset values, unmapped access, decode table, then the timed cases
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1;
      @(negedge clk);
      chk(pm_n, 0);
      @(posedge clk);
      rc(ADDR_CS_CTRL, 8'h33);
      rc(ADDR_HOLE_SIZE, 8'h00);
      wr(6'h28, 8'h00);
      chk(resp, 2);
      wr(ADDR_ROM_FWD, 8'h81);
      wr(ADDR_HOLE_START, 8'h0c);
      wr(ADDR_CS_CTRL, 8'he3);
      cv <= 1;
      foreach (tbl[i]) begin
         wr(ADDR_HOLE_SIZE, tbl[i][45:38]);
         {cm, cw, ci, ca} <= tbl[i][37:3];
         repeat (2) @(posedge clk);
         @(negedge clk);
         chk(fwd, tbl[i][2]);
         chk(xcs, tbl[i][1:0]);
         @(posedge clk);
      end
      ca <= 32'h92;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(p92, 1);
      @(posedge clk);
      $display("decode test done");
      wr(ADDR_IRQ_WAKE, 8'h04);
      wr(ADDR_INT_MASK, 8'h02);
      lines <= 8'h04;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk({pm_n, irq}, 2'b11);
      @(posedge clk);
      rc(ADDR_INT_STAT, 8'h02);
      @(negedge clk);
      chk(irq, 0);
      @(posedge clk);
      // Recovery: none while disabled, then 8 ISA clocks of 4 PCI clocks
      iod <= 1;
      @(posedge clk);
      iod <= 0;
      @(negedge clk);
      chk(rec, 0);
      @(posedge clk);
      wr(ADDR_BUS_CTRL, 8'h04);
      iod <= 1;
      @(posedge clk);
      iod <= 0;
      repeat (28) @(posedge clk);
      @(negedge clk);
      chk(rec, 1);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(rec, 0);
      @(posedge clk);
      $display("recovery test done");
      wr(ADDR_SYS_CTRL, 8'h16);
      byt <= KBC_CMD_RESET;
      go <= 1;
      @(posedge clk);
      go <= 0;
      repeat (20) @(posedge clk);
      chk(ninit > 4, 1);
      sp <= 0;
      @(posedge clk);
      @(negedge clk);
      chk(coprocessor_error_n_n, 0);
      @(posedge clk);
      x86 <= 0;
      wr(ADDR_CLK_DIV, 8'h08);
      repeat (40) @(posedge clk);
      chk(nrst, 20);
      rc(ADDR_CLK_DIV, 8'h00);
      go <= 1;
      @(posedge clk);
      go <= 0;
      repeat (30) @(posedge clk);
      chk(nhrst, 20);
      $display("event test done");
      finish_test();
   end
endmodule
